// *** design/flash_seq_pkg.sv ***
// Shared constants and types of the flash command sequencer
package flash_seq_pkg;
  localparam int unsigned BUS_KHZ = 20_000;
  localparam int unsigned DIVIDED_CMD_CLOCK_MIN_KHZ = 150;
  localparam int unsigned DIVIDED_CMD_CLOCK_MAX_KHZ = 200;
  // Allowed total divisor in bus cycles: fastest rate rounds up, slowest rounds down
  localparam logic [9:0] DIV_MIN = 10'((BUS_KHZ + DIVIDED_CMD_CLOCK_MAX_KHZ - 1) / DIVIDED_CMD_CLOCK_MAX_KHZ);
  localparam logic [9:0] DIV_MAX = 10'(BUS_KHZ / DIVIDED_CMD_CLOCK_MIN_KHZ);
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int PAGE_LSB = 9;
  localparam int ROW_LSB = 6;
  localparam int DIV_PRE_BIT = 6;
  localparam int DIV_VAL_W = 6;
  localparam int PRE_SHIFT = 3;
  localparam int CNT_W = 15;
  localparam logic [CNT_W-1:0] BYTE_CYC = 15'h0009;
  localparam logic [CNT_W-1:0] BURST_CYC = 15'h0004;
  localparam logic [CNT_W-1:0] BLANK_CYC = 15'h0001;
  localparam int PAGE_CYC_DEF = 4000;
  localparam int MASS_CYC_DEF = 20000;
  localparam logic [7:0] CMD_BLANK = 8'h05;
  localparam logic [7:0] CMD_BYTE = 8'h20;
  localparam logic [7:0] CMD_BURST = 8'h25;
  localparam logic [7:0] CMD_PAGE = 8'h40;
  localparam logic [7:0] CMD_MASS = 8'h41;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_ADDR = 2'b01,
    SEQ_CMD = 2'b11
  } seq_state_t;
  typedef enum logic {
    EX_IDLE = 1'b0,
    EX_RUN = 1'b1
  } ex_state_t;
endpackage

// *** design/divided_cmd_clock_if.sv ***
// Link between the sequencer, its clock divider and its operation timer
`timescale 1ns/100ps
interface divided_cmd_clock_if;
  logic div_load;
  logic [7:0] div_setting;
  logic tick;
  logic tmr_start;
  logic [flash_seq_pkg::CNT_W-1:0] tmr_count;
  logic tmr_stop;
  logic tmr_done;
  modport ctrl (output div_load, div_setting, tmr_start, tmr_count, tmr_stop, input tick, tmr_done);
  modport divider (input div_load, div_setting, output tick);
  modport timer (input tick, tmr_start, tmr_count, tmr_stop, output tmr_done);
endinterface

// *** design/divided_cmd_clock_divider.sv ***
// Divided command clock as a one-cycle enable pulse
`timescale 1ns/100ps
module divided_cmd_clock_divider (
  input wire logic i_clk, // Bus clock
  input wire logic i_rst, // Async reset, active high
  divided_cmd_clock_if.divider fif     // Divider side of the link
);
  logic [9:0] period_q, period_d;
  logic [9:0] cnt_q, cnt_d;
  logic [9:0] base;
  logic run_q, run_d;
  logic tick_q, tick_d;

  always_comb begin
    period_d = period_q;
    cnt_d = cnt_q;
    run_d = run_q;
    tick_d = 1'b0;
    base = {4'h0, fif.div_setting[flash_seq_pkg::DIV_VAL_W-1:0]} + 10'h001;
    if (fif.div_load) begin
      period_d = fif.div_setting[flash_seq_pkg::DIV_PRE_BIT] ? (base << flash_seq_pkg::PRE_SHIFT) : base;
      cnt_d = 10'h000;
      run_d = 1'b1;
    end else if (run_q) begin
      if (cnt_q == 10'h000) begin
        cnt_d = period_q - 10'h001;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q - 10'h001;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      period_q <= 10'h001;
      cnt_q <= 10'h000;
      run_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      period_q <= period_d;
      cnt_q <= cnt_d;
      run_q <= run_d;
      tick_q <= tick_d;
    end
  end

  assign fif.tick = tick_q;

  tick_spacing_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (tick_q && period_q > 10'h001 && !fif.div_load) |=> !tick_q)
    else $error("divided clock ticked twice in a row");
endmodule // divided_cmd_clock_divider

// *** design/op_timer.sv ***
// Counts divided-clock periods of one program or erase operation
`timescale 1ns/100ps
module op_timer (
  input wire logic i_clk, // Bus clock
  input wire logic i_rst, // Async reset, active high
  divided_cmd_clock_if.timer fif       // Timer side of the link
);
  logic [flash_seq_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic busy_q, busy_d;
  logic done_q, done_d;

  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (fif.tmr_stop) begin
      busy_d = 1'b0;
    end else if (fif.tmr_start) begin
      cnt_d = fif.tmr_count;
      busy_d = 1'b1;
    end else if (busy_q && fif.tick) begin
      cnt_d = cnt_q - 15'h0001;
      if (cnt_q == 15'h0001) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 15'h0000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign fif.tmr_done = done_q;

  done_after_busy_a: assert property (@(posedge i_clk) disable iff (i_rst)
    done_q |-> ($past(busy_q) && !busy_q && cnt_q == 15'h0000))
    else $error("operation finished without a running count");
endmodule // op_timer

// *** design/flash_cmd_sequencer.sv ***
// Command sequencer of the program flash: protocol, error checks, timing and pump
//
// Functional notes
// - Divided clock 150 to 200 kHz first; code only requires a divider write and flags the band
// - Divider written once, not while error
// - Program 9, page 4000, mass 20000 periods
// - Further burst bytes take 4 periods
// - Array write latches address and data
// - Page erase whole page; mass ignores address
// - Five command codes latched into buffer
// - Writing one to buffer-empty launches command
// - Writing zero mid-sequence aborts with error
// - Complete flag shows command finished
// - Pump stays on for queued same-row burst
// - Row is 64 bytes; row start standard
// - First burst byte takes standard time
// - Nothing queued: pump off at completion
// - Array write before divider set errors
// - Array write with buffer full errors
// - Second array or command write errors
// - Other control write mid-sequence, or read after command, errors
// - Unknown command code errors
// - Stop mode aborts operation with error
// - Secured debug port: only blank, mass
`timescale 1ns/100ps
module flash_cmd_sequencer #(
  parameter int PAGE_CYC = flash_seq_pkg::PAGE_CYC_DEF, // Page erase periods
  parameter int MASS_CYC = flash_seq_pkg::MASS_CYC_DEF  // Mass erase periods
) (
  input wire logic i_clk,                                       // Bus clock, 20 MHz
  input wire logic i_rst,                                       // Async reset, active high
  input wire logic i_array_wr,                                  // Write strobe to the array space
  input wire logic [flash_seq_pkg::ADDR_W-1:0] i_array_addr,    // Array write address
  input wire logic [flash_seq_pkg::DATA_W-1:0] i_array_data,    // Array write data
  input wire logic i_div_wr,                                    // Write strobe to divider register
  input wire logic [7:0] i_div_data,                            // Divider value written
  input wire logic i_cmd_wr,                                    // Write strobe to command register
  input wire logic [7:0] i_cmd_code,                            // Command code written
  input wire logic i_stat_wr,                                   // Write strobe to status register
  input wire logic i_stat_cbef,                                 // Buffer-empty bit of that write
  input wire logic i_stat_accerr,                               // Error bit of that write
  input wire logic i_other_ctl_wr,                              // Write to any other control register
  input wire logic i_ctl_rd,                                    // Read of any control register
  input wire logic i_debug_port,                                // Access comes from the debug port
  input wire logic i_secured,                                   // Part is secured
  input wire logic i_stop,                                      // Processor enters stop mode
  output logic o_cmd_buffer_empty_flag,                         // Command buffer empty
  output logic o_cmd_complete_flag,                             // All commands finished
  output logic o_access_error_flag,                             // Protocol violated
  output logic o_div_loaded,                                    // Divider has been written
  output logic o_div_in_range,                                  // Divided clock inside its band
  output logic o_hv_pump_on,                                    // Charge pump enable
  output logic o_prog_active,                                   // Byte program pulse on
  output logic o_erase_active,                                  // Erase pulse on
  output logic o_mass_erase,                                    // Erase covers the whole array
  output logic o_blank_check,                                   // Blank check running
  output logic [flash_seq_pkg::ADDR_W-1:0] o_array_addr,        // Target address of operation
  output logic [flash_seq_pkg::DATA_W-1:0] o_array_data         // Data to program
);
  if (PAGE_CYC < 1 || PAGE_CYC >= 2 ** flash_seq_pkg::CNT_W || MASS_CYC < 1 ||
      MASS_CYC >= 2 ** flash_seq_pkg::CNT_W) begin : g_bad_cycles
    $error("erase period counts do not fit the timer");
  end

  divided_cmd_clock_if fif ();

  divided_cmd_clock_divider u_div (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .fif(fif.divider)
  );

  op_timer u_tmr (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .fif(fif.timer)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Command protocol and error checks

  flash_seq_pkg::seq_state_t seq_q, seq_d;
  flash_seq_pkg::ex_state_t ex_q, ex_d;
  logic [flash_seq_pkg::ADDR_W-1:0] lat_addr_q, lat_addr_d;
  logic [flash_seq_pkg::DATA_W-1:0] lat_data_q, lat_data_d;
  logic [7:0] lat_cmd_q, lat_cmd_d;
  logic [7:0] divval_q, divval_d;
  logic cbef_q, cbef_d;
  logic comp_q, comp_d;
  logic err_q, err_d;
  logic divld_q, divld_d;
  logic inrange_q, inrange_d;
  logic err_set;
  logic code_ok;
  logic code_secure_bad;
  logic any_access;
  logic launch;
  logic [9:0] div_base;
  logic [9:0] div_eff;
  logic take;
  logic abort;

  always_comb begin
    seq_d = seq_q;
    lat_addr_d = lat_addr_q;
    lat_data_d = lat_data_q;
    lat_cmd_d = lat_cmd_q;
    divval_d = divval_q;
    cbef_d = cbef_q;
    divld_d = divld_q;
    inrange_d = inrange_q;
    err_set = 1'b0;
    launch = 1'b0;
    fif.div_load = 1'b0;
    fif.div_setting = i_div_data;
    code_ok = (i_cmd_code == flash_seq_pkg::CMD_BLANK) || (i_cmd_code == flash_seq_pkg::CMD_BYTE) ||
              (i_cmd_code == flash_seq_pkg::CMD_BURST) || (i_cmd_code == flash_seq_pkg::CMD_PAGE) ||
              (i_cmd_code == flash_seq_pkg::CMD_MASS);
    code_secure_bad = i_debug_port && i_secured && ((i_cmd_code == flash_seq_pkg::CMD_BYTE) ||
                      (i_cmd_code == flash_seq_pkg::CMD_BURST) || (i_cmd_code == flash_seq_pkg::CMD_PAGE));
    any_access = i_array_wr || i_div_wr || i_cmd_wr || i_stat_wr || i_other_ctl_wr || i_ctl_rd;
    div_base = {4'h0, i_div_data[flash_seq_pkg::DIV_VAL_W-1:0]} + 10'h001;
    div_eff = i_div_data[flash_seq_pkg::DIV_PRE_BIT] ? (div_base << flash_seq_pkg::PRE_SHIFT) : div_base;
    if (take) begin
      cbef_d = 1'b1;
    end
    case (seq_q)
      flash_seq_pkg::SEQ_IDLE: begin
        if (i_array_wr) begin
          if (!divld_q || !cbef_q) begin
            err_set = 1'b1;
          end else if (!err_q) begin
            seq_d = flash_seq_pkg::SEQ_ADDR;
            lat_addr_d = i_array_addr;
            lat_data_d = i_array_data;
          end
        end
        if (i_cmd_wr) begin
          err_set = 1'b1;
        end
        // A divider write is only taken once and never while the error flag stands
        if (i_div_wr && !divld_q && !err_q) begin
          divval_d = i_div_data;
          divld_d = 1'b1;
          inrange_d = (div_eff >= flash_seq_pkg::DIV_MIN) && (div_eff <= flash_seq_pkg::DIV_MAX);
          fif.div_load = 1'b1;
        end
      end
      flash_seq_pkg::SEQ_ADDR: begin
        if (i_array_wr || i_div_wr || i_other_ctl_wr || i_stat_wr) begin
          err_set = 1'b1;
        end else if (i_cmd_wr) begin
          if (!code_ok || code_secure_bad) begin
            err_set = 1'b1;
          end else begin
            lat_cmd_d = i_cmd_code;
            seq_d = flash_seq_pkg::SEQ_CMD;
          end
        end
      end
      flash_seq_pkg::SEQ_CMD: begin
        if (i_stat_wr && i_stat_cbef && !(i_array_wr || i_div_wr || i_cmd_wr || i_other_ctl_wr || i_ctl_rd)) begin
          launch = 1'b1;
          seq_d = flash_seq_pkg::SEQ_IDLE;
        end else if (any_access) begin
          err_set = 1'b1;
        end
      end
      default: begin
        seq_d = flash_seq_pkg::SEQ_IDLE;
      end
    endcase
    if (launch) begin
      cbef_d = 1'b0;
    end
    // Any violation, stop-mode abort included, throws away the partial sequence
    if ((err_set || abort) && seq_q != flash_seq_pkg::SEQ_IDLE) begin
      seq_d = flash_seq_pkg::SEQ_IDLE;
    end
    // Set wins over the software clear so no violation is lost
    err_d = err_set || abort || (err_q && !(i_stat_wr && i_stat_accerr));
    comp_d = cbef_d && (ex_d == flash_seq_pkg::EX_IDLE);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      seq_q <= flash_seq_pkg::SEQ_IDLE;
      lat_addr_q <= 13'h0000;
      lat_data_q <= 8'h00;
      lat_cmd_q <= 8'h00;
      divval_q <= 8'h00;
      cbef_q <= 1'b1;
      comp_q <= 1'b1;
      err_q <= 1'b0;
      divld_q <= 1'b0;
      inrange_q <= 1'b0;
    end else begin
      seq_q <= seq_d;
      lat_addr_q <= lat_addr_d;
      lat_data_q <= lat_data_d;
      lat_cmd_q <= lat_cmd_d;
      divval_q <= divval_d;
      cbef_q <= cbef_d;
      comp_q <= comp_d;
      err_q <= err_d;
      divld_q <= divld_d;
      inrange_q <= inrange_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Execution, timing and charge pump

  logic pump_q, pump_d;
  logic prog_q, prog_d;
  logic erase_q, erase_d;
  logic mass_q, mass_d;
  logic blank_q, blank_d;
  logic burst_q, burst_d;
  logic [flash_seq_pkg::ADDR_W-1:0] oaddr_q, oaddr_d;
  logic [flash_seq_pkg::DATA_W-1:0] odata_q, odata_d;
  logic cont;
  logic same_row;

  always_comb begin
    ex_d = ex_q;
    pump_d = pump_q;
    prog_d = prog_q;
    erase_d = erase_q;
    mass_d = mass_q;
    blank_d = blank_q;
    burst_d = burst_q;
    oaddr_d = oaddr_q;
    odata_d = odata_q;
    take = 1'b0;
    cont = 1'b0;
    abort = 1'b0;
    fif.tmr_start = 1'b0;
    fif.tmr_stop = 1'b0;
    fif.tmr_count = flash_seq_pkg::BYTE_CYC;
    // A byte at row offset zero opens a new row and takes the standard program time
    same_row = (lat_addr_q[flash_seq_pkg::ADDR_W-1:flash_seq_pkg::ROW_LSB] ==
                oaddr_q[flash_seq_pkg::ADDR_W-1:flash_seq_pkg::ROW_LSB]) &&
               (lat_addr_q[flash_seq_pkg::ROW_LSB-1:0] != 6'h00);
    if (ex_q == flash_seq_pkg::EX_RUN && i_stop) begin
      abort = 1'b1;
      fif.tmr_stop = 1'b1;
    end else if (ex_q == flash_seq_pkg::EX_IDLE && !cbef_q) begin
      take = 1'b1;
    end else if (ex_q == flash_seq_pkg::EX_RUN && fif.tmr_done) begin
      if (!cbef_q) begin
        take = 1'b1;
        cont = burst_q && pump_q && (lat_cmd_q == flash_seq_pkg::CMD_BURST) && same_row;
      end else begin
        ex_d = flash_seq_pkg::EX_IDLE;
        pump_d = 1'b0;
        prog_d = 1'b0;
        erase_d = 1'b0;
        mass_d = 1'b0;
        blank_d = 1'b0;
        burst_d = 1'b0;
      end
    end
    if (abort) begin
      ex_d = flash_seq_pkg::EX_IDLE;
      pump_d = 1'b0;
      prog_d = 1'b0;
      erase_d = 1'b0;
      mass_d = 1'b0;
      blank_d = 1'b0;
      burst_d = 1'b0;
    end
    if (take) begin
      ex_d = flash_seq_pkg::EX_RUN;
      fif.tmr_start = 1'b1;
      prog_d = (lat_cmd_q == flash_seq_pkg::CMD_BYTE) || (lat_cmd_q == flash_seq_pkg::CMD_BURST);
      erase_d = (lat_cmd_q == flash_seq_pkg::CMD_PAGE) || (lat_cmd_q == flash_seq_pkg::CMD_MASS);
      mass_d = (lat_cmd_q == flash_seq_pkg::CMD_MASS);
      blank_d = (lat_cmd_q == flash_seq_pkg::CMD_BLANK);
      burst_d = (lat_cmd_q == flash_seq_pkg::CMD_BURST);
      pump_d = (lat_cmd_q != flash_seq_pkg::CMD_BLANK);
      oaddr_d = lat_addr_q;
      odata_d = lat_data_q;
      case (lat_cmd_q)
        flash_seq_pkg::CMD_BURST: begin
          fif.tmr_count = cont ? flash_seq_pkg::BURST_CYC : flash_seq_pkg::BYTE_CYC;
        end
        flash_seq_pkg::CMD_PAGE: begin
          fif.tmr_count = flash_seq_pkg::CNT_W'(PAGE_CYC);
          oaddr_d = {lat_addr_q[flash_seq_pkg::ADDR_W-1:flash_seq_pkg::PAGE_LSB], 9'h000};
          odata_d = 8'h00;
        end
        flash_seq_pkg::CMD_MASS: begin
          fif.tmr_count = flash_seq_pkg::CNT_W'(MASS_CYC);
          oaddr_d = 13'h0000;
          odata_d = 8'h00;
        end
        flash_seq_pkg::CMD_BLANK: begin
          fif.tmr_count = flash_seq_pkg::BLANK_CYC;
          oaddr_d = 13'h0000;
          odata_d = 8'h00;
        end
        default: begin
          fif.tmr_count = flash_seq_pkg::BYTE_CYC;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ex_q <= flash_seq_pkg::EX_IDLE;
      pump_q <= 1'b0;
      prog_q <= 1'b0;
      erase_q <= 1'b0;
      mass_q <= 1'b0;
      blank_q <= 1'b0;
      burst_q <= 1'b0;
      oaddr_q <= 13'h0000;
      odata_q <= 8'h00;
    end else begin
      ex_q <= ex_d;
      pump_q <= pump_d;
      prog_q <= prog_d;
      erase_q <= erase_d;
      mass_q <= mass_d;
      blank_q <= blank_d;
      burst_q <= burst_d;
      oaddr_q <= oaddr_d;
      odata_q <= odata_d;
    end
  end

  assign o_cmd_buffer_empty_flag = cbef_q;
  assign o_cmd_complete_flag = comp_q;
  assign o_access_error_flag = err_q;
  assign o_div_loaded = divld_q;
  assign o_div_in_range = inrange_q;
  assign o_hv_pump_on = pump_q;
  assign o_prog_active = prog_q;
  assign o_erase_active = erase_q;
  assign o_mass_erase = mass_q;
  assign o_blank_check = blank_q;
  assign o_array_addr = oaddr_q;
  assign o_array_data = odata_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  nodiv_error_a: assert property ((seq_q == flash_seq_pkg::SEQ_IDLE && i_array_wr && !divld_q) |=>
    (err_q && seq_q == flash_seq_pkg::SEQ_IDLE)) else $error("array write before divider not flagged");
  busy_error_a: assert property ((seq_q == flash_seq_pkg::SEQ_IDLE && i_array_wr && !cbef_q) |=>
    err_q) else $error("array write with full buffer not flagged");
  bad_code_a: assert property ((seq_q == flash_seq_pkg::SEQ_ADDR && i_cmd_wr && !code_ok && !i_array_wr &&
    !i_div_wr && !i_other_ctl_wr && !i_stat_wr) |=> (err_q && seq_q == flash_seq_pkg::SEQ_IDLE))
    else $error("unknown command code accepted");
  launch_a: assert property ((seq_q == flash_seq_pkg::SEQ_CMD && i_stat_wr && i_stat_cbef && !i_array_wr &&
    !i_div_wr && !i_cmd_wr && !i_other_ctl_wr && !i_ctl_rd) |=>
    (!cbef_q && !comp_q && (take || ex_q == flash_seq_pkg::EX_RUN)))
    else $error("launch did not queue the command");
  abort_a: assert property ((seq_q != flash_seq_pkg::SEQ_IDLE && i_stat_wr && !i_stat_cbef) |=>
    (err_q && seq_q == flash_seq_pkg::SEQ_IDLE && cbef_q)) else $error("abort did not flag an error");
  div_once_a: assert property (divld_q |=> ($stable(divval_q) && divld_q))
    else $error("divider changed after its one write");
  stop_abort_a: assert property ((ex_q == flash_seq_pkg::EX_RUN && i_stop) |=>
    (ex_q == flash_seq_pkg::EX_IDLE && err_q && !pump_q && !prog_q && !erase_q))
    else $error("stop mode did not abort the operation");
  err_hold_a: assert property ((err_q && !(i_stat_wr && i_stat_accerr)) |=>
    (err_q && seq_q == flash_seq_pkg::SEQ_IDLE)) else $error("error flag dropped without a clear");
  pump_off_a: assert property ((ex_q == flash_seq_pkg::EX_RUN && fif.tmr_done && cbef_q && !i_stop) |=>
    (!pump_q && comp_q == cbef_q)) else $error("pump left on with nothing queued");
  secure_a: assert property ((seq_q == flash_seq_pkg::SEQ_ADDR && i_cmd_wr && code_secure_bad) |=>
    (err_q && seq_q == flash_seq_pkg::SEQ_IDLE)) else $error("secured debug command accepted");
endmodule // flash_cmd_sequencer

// *** test/host_bus_model.sv ***
// Host model issuing the writes and reads of a flash command sequence
`timescale 1ns/100ps
module host_bus_model (
  input wire logic i_clk,      // Bus clock
  output logic [5:0] o_strobe, // Array, divider, command, status, other, read
  output logic [12:0] o_addr,  // Array address
  output logic [7:0] o_data,   // Array data, divider value or command code
  output logic [1:0] o_stat    // Status write: buffer-empty, error bits
);
  initial begin
    o_strobe = 6'h00;
    o_addr = 13'h0000;
    o_data = 8'h00;
    o_stat = 2'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One access a call; callers never program a byte twice between erases
  task automatic put(input int k, input logic [12:0] a, input logic [7:0] d, input logic [1:0] s);
    @(posedge i_clk);
    #1;
    o_strobe = 6'h01 << k;
    o_addr = a;
    o_data = d;
    o_stat = s;
    @(posedge i_clk);
    #1;
    // Released bus shows the inverse, so stale values never pass
    o_strobe = 6'h00;
    o_addr = ~a;
    o_data = ~d;
    o_stat = ~s;
  endtask
  // Two accesses on consecutive edges, sharing address, data and status bits
  task automatic put2(input int k1, input int k2, input logic [12:0] a, input logic [7:0] d,
                      input logic [1:0] s);
    @(posedge i_clk);
    #1;
    o_strobe = 6'h01 << k1;
    o_addr = a;
    o_data = d;
    o_stat = s;
    @(posedge i_clk);
    #1;
    o_strobe = 6'h01 << k2;
    @(posedge i_clk);
    #1;
    o_strobe = 6'h00;
    o_addr = ~a;
    o_data = ~d;
    o_stat = ~s;
  endtask
endmodule // host_bus_model

// *** test/tb.sv ***
// Self-checking bench of the flash command sequencer
`timescale 1ns/100ps
module tb;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic dbg = 1'b0;
  logic sec = 1'b0;
  logic stp = 1'b0;
  logic [5:0] str;
  logic [12:0] addr, oaddr;
  logic [7:0] data, odata;
  logic [1:0] stat;
  logic cbef, ccf, err, dld, drng, pump, prog, ers, mass, blank;
  int err_count = 0;
  int checks_done = 0;
  always #25 i_clk = ~i_clk;
  host_bus_model u_host (.i_clk(i_clk), .o_strobe(str), .o_addr(addr), .o_data(data), .o_stat(stat));
  flash_cmd_sequencer #(.PAGE_CYC(5), .MASS_CYC(7)) u_flash_cmd_sequencer (
    .i_clk(i_clk), .i_rst(i_rst), .i_array_wr(str[0]), .i_array_addr(addr), .i_array_data(data),
    .i_div_wr(str[1]), .i_div_data(data), .i_cmd_wr(str[2]), .i_cmd_code(data), .i_stat_wr(str[3]),
    .i_stat_cbef(stat[1]), .i_stat_accerr(stat[0]), .i_other_ctl_wr(str[4]), .i_ctl_rd(str[5]),
    .i_debug_port(dbg), .i_secured(sec), .i_stop(stp), .o_cmd_buffer_empty_flag(cbef),
    .o_cmd_complete_flag(ccf), .o_access_error_flag(err), .o_div_loaded(dld), .o_div_in_range(drng),
    .o_hv_pump_on(pump), .o_prog_active(prog), .o_erase_active(ers), .o_mass_erase(mass),
    .o_blank_check(blank), .o_array_addr(oaddr), .o_array_data(odata));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask
  task automatic seq(input logic [7:0] code, input logic [12:0] a, input logic [7:0] d);
    u_host.put(0, a, d, 2'h0);
    u_host.put(2, 13'h0000, code, 2'h0);
    u_host.put(3, 13'h0000, 8'h00, 2'h2);
  endtask
  task automatic clr();
    u_host.put(3, 13'h0000, 8'h00, 2'h1);
    tick();
  endtask
  // Divider of 4 bus cycles a tick keeps op times short
  task automatic run_len(output int n);
    n = 0;
    while (ccf !== 1'b1 && n < 1000) begin
      tick();
      n++;
    end
    chk(ccf, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_div();
    chk({cbef, ccf, err, dld, pump, prog}, 6'h30);
    u_host.put(0, 13'h0010, 8'h5A, 2'h0);
    tick();
    chk(err, 1'b1);
    seq(8'h20, 13'h0010, 8'h5A);
    tick();
    chk({ccf, prog, err}, 3'h5);
    u_host.put(1, 13'h0000, 8'h03, 2'h0);
    tick();
    chk(dld, 1'b0);
    clr();
    chk(err, 1'b0);
    u_host.put(1, 13'h0000, 8'h03, 2'h0);
    tick();
    chk({dld, drng}, 2'h2);
    $display("test reset_div done");
  endtask
  task automatic t_byte();
    int n;
    seq(8'h20, 13'h0123, 8'hC3);
    tick();
    tick();
    chk({prog, pump, ccf, oaddr, odata}, {3'h6, 13'h0123, 8'hC3});
    run_len(n);
    chk(n >= 30 && n <= 40, 1'b1);
    chk({prog, pump}, 2'h0);
    $display("test byte done");
  endtask
  task automatic t_burst();
    int n;
    int lows;
    logic [12:0] a1 [2] = '{13'h0101, 13'h013F};
    for (int i = 0; i < 2; i++) begin
      lows = 0;
      seq(8'h25, a1[i], 8'h11);
      tick();
      seq(8'h25, a1[i] + 13'h0001, 8'h22);
      n = 7;
      while (ccf !== 1'b1 && n < 1000) begin
        tick();
        n++;
        lows += (pump !== 1'b1 && ccf !== 1'b1);
      end
      chk(i == 0 ? (n >= 48 && n <= 60) : (n >= 68 && n <= 80), 1'b1);
      chk(lows, 0);
      chk(pump, 1'b0);
    end
    $display("test burst done");
  endtask
  task automatic t_errors();
    int n;
    for (int i = 0; i < 6; i++) begin
      u_host.put(0, 13'h0040, 8'h00, 2'h0);
      case (i)
        0: u_host.put(2, 13'h0000, 8'h33, 2'h0);
        1: u_host.put(3, 13'h0000, 8'h00, 2'h0);
        2: u_host.put(0, 13'h0041, 8'h00, 2'h0);
        3: u_host.put(4, 13'h0000, 8'h00, 2'h0);
        default: begin
          u_host.put(2, 13'h0000, 8'h20, 2'h0);
          u_host.put(i == 4 ? 2 : 5, 13'h0000, 8'h20, 2'h0);
        end
      endcase
      tick();
      chk({err, ccf, prog}, 3'h6);
      clr();
    end
    u_host.put(0, 13'h0040, 8'h00, 2'h0);
    u_host.put(2, 13'h0000, 8'h05, 2'h0);
    u_host.put2(3, 0, 13'h0040, 8'h00, 2'h2);
    chk({err, ccf}, 2'h2);
    run_len(n);
    clr();
    $display("test errors done");
  endtask
  task automatic t_erase_stop();
    int n;
    seq(8'h40, 13'h0555, 8'h00);
    run_len(n);
    chk(n >= 16 && n <= 24, 1'b1);
    seq(8'h40, 13'h03FF, 8'hFF);
    tick();
    tick();
    chk({ers, mass, oaddr, odata}, {2'h2, 13'h0200, 8'h00});
    stp = 1'b1;
    tick();
    stp = 1'b0;
    tick();
    chk({err, ers, pump}, 3'h4);
    clr();
    $display("test erase_stop done");
  endtask
  task automatic t_secured();
    int n;
    logic [7:0] bad [3] = '{8'h20, 8'h25, 8'h40};
    dbg = 1'b1;
    sec = 1'b1;
    foreach (bad[i]) begin
      u_host.put(0, 13'h0800, 8'h00, 2'h0);
      u_host.put(2, 13'h0000, bad[i], 2'h0);
      tick();
      chk(err, 1'b1);
      clr();
    end
    seq(8'h41, 13'h1ABC, 8'h77);
    tick();
    tick();
    chk({mass, ers, oaddr, odata}, {2'h3, 21'h000000});
    run_len(n);
    chk(n >= 24 && n <= 32, 1'b1);
    seq(8'h05, 13'h0155, 8'h00);
    tick();
    tick();
    chk({blank, err}, 2'h2);
    run_len(n);
    dbg = 1'b0;
    sec = 1'b0;
    $display("test secured done");
  endtask
  // Second reset mid-run, then a divider inside the band
  task automatic t_in_range();
    int n;
    i_rst = 1'b1;
    tick();
    i_rst = 1'b0;
    tick();
    chk({cbef, ccf, err, dld, drng, pump}, 6'h30);
    u_host.put(1, 13'h0000, 8'h4C, 2'h0);
    tick();
    chk({dld, drng}, 2'h3);
    seq(8'h05, 13'h0000, 8'h00);
    run_len(n);
    chk(n >= 2 && n <= 106, 1'b1);
    $display("test in_range done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    tick();
    t_reset_div();
    t_byte();
    t_burst();
    t_errors();
    t_erase_stop();
    t_secured();
    t_in_range();
    end_of_test();
  end
  // Whole run needs well under 2000 cycles
  initial begin
    #(50 * 5000);
    err_count++;
    end_of_test();
  end
endmodule // tb
